// ==== src/sonet_packet_mac_stats.v ====
// Overview of operation
// R1 - oversize when byte count incl crc exceeds limit
// R2 - oversize receive aborts, flags port and frame
// R3 - aborted port ignores data until next start
// R4 - software discards aborted frame; egress drops forwarded
// R5 - receive frame counters at four n plus k
// R6 - count every received octet at 0x10 plus n; octets that an aborted port ignores until its next start are not counted
// R7 - bad crc only when length within limit
// R8 - good only when not oversize, crc ok
// R9 - framer error frames counted in error counter
// R10 - transmit counters at documented locations per port
// R11 - transmit octets include octets of errored frames
// R12 - three egress errors abort frame, count it
// R13 - abort captures cause into indicator register
// R14 - descriptor error keeps buffers off free queue
// R15 - underrun counted only by earlier revision
// R16 - per-frame crc insertion enable or disable
// R17 - short frames take an 18-byte slot
// R18 - 8-bit quad port or 32-bit single port
// R19 - back-pressure throttles reception to avoid loss
// R20 - frame counters updated once at end or abort
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pos_mac_stats_regs.vh"
module sonet_packet_mac_stats #(
  parameter EARLY_REVISION = 0
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [11:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [11:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // receive pins from framer
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_err,
  input wire [1:0] rx_port,
  input wire [2:0] rx_bytes,
  input wire [31:0] rx_data,
  output reg rx_enable,
  // receive back-pressure and abort records
  input wire rx_hold,
  output reg rx_frame_abort,
  output reg [1:0] rx_abort_port,
  output reg [3:0] rx_port_aborted,
  // transmit stream from egress
  input wire tx_valid,
  input wire tx_sof,
  input wire tx_eof,
  input wire [1:0] tx_port,
  input wire [2:0] tx_bytes,
  input wire [31:0] tx_data,
  input wire tx_crc_en,
  input wire tx_underrun,
  input wire tx_link_parity_err,
  input wire tx_queue_start_field_err,
  input wire tx_buffer_control_descriptor_err,
  // transmit results
  output reg tx_abort,
  output reg tx_free_return,
  output reg [31:0] tx_fcs,
  output reg tx_fcs_valid,
  output reg [1:0] tx_fcs_port
);
  // ****************************************************************
  // functions
  // ****************************************************************
  // reflected crc-32 over up to four bytes, msb byte first
  function [31:0] crc_word;
    input [31:0] c_in;
    input [31:0] d;
    input [2:0] n;
    integer i;
    integer b;
    reg [31:0] c;
    begin
      c = c_in;
      for (i = 0; i < 4; i = i + 1) begin
        if (i < n) begin
          c = c ^ {24'h000000, d[31 - 8 * i -: 8]};
          for (b = 0; b < 8; b = b + 1) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY_REV) : (c >> 1);
          end
        end
      end
      crc_word = c;
    end
  endfunction
  // counter ram index for port p and frame kind k
  function [4:0] frame_idx;
    input [1:0] p;
    input [1:0] k;
    begin
      frame_idx = {1'b0, p, k};
    end
  endfunction
  // ****************************************************************
  // state
  // ****************************************************************
  reg [43:0] rx_meta;  // first synchroniser stage
  reg [43:0] rx_sync;  // second stage, read by logic
  reg mode32;  // 32-bit single port mode
  reg [15:0] max_fs;  // frame size limit
  reg [4:0] abort_ind;  // cause bits and port
  reg [31:0] rx_cnt [0:`CNT_ENTRIES-1];  // receive counter ram
  reg [31:0] tx_cnt [0:`CNT_ENTRIES-1];  // transmit counter ram
  reg [15:0] rx_len [0:3];  // per-port running length
  reg [31:0] rx_crc [0:3];  // per-port crc state
  reg [15:0] tx_len [0:3];
  reg [31:0] tx_crc [0:3];
  reg [3:0] rx_drop;  // port ignoring data
  reg [3:0] rx_ferr;  // framer error seen this frame
  reg [15:0] stall_cnt;  // short-frame slot filler
  reg aw_full;
  reg w_full;
  reg [11:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  // synchronised receive fields
  wire s_valid = rx_sync[43];
  wire s_sof = rx_sync[42];
  wire s_eof = rx_sync[41];
  wire s_err = rx_sync[40];
  wire [1:0] s_port = rx_sync[39:38];
  wire [2:0] s_bytes = rx_sync[37:35];
  wire [31:0] s_data = rx_sync[31:0];
  // combinational next values
  reg [1:0] rx_p;
  reg [2:0] rx_n;
  reg [15:0] next_rx_len;
  reg [31:0] next_rx_crc;
  reg rx_live;
  reg rx_over;
  reg [1:0] tx_p;
  reg [2:0] tx_n;
  reg [15:0] next_tx_len;
  reg [31:0] next_tx_crc;
  reg [15:0] tx_final_len;
  reg tx_any_abort;
  reg [31:0] rd_val;
  reg rd_err;
  integer k;
  integer j;  // transmit reset loops
  // ****************************************************************
  // receive pin synchroniser
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 44'h00000000000;
      rx_sync <= 44'h00000000000;
    end else begin
      rx_meta <= {rx_valid, rx_sof, rx_eof, rx_err, rx_port, rx_bytes, 3'b000, rx_data};
      rx_sync <= rx_meta;
    end
  end
  // ****************************************************************
  // per-beat decode
  // ****************************************************************
  always @* begin
    // single port and 32-bit beats in wide mode
    rx_p = mode32 ? 2'b00 : s_port;  // R18
    rx_n = mode32 ? s_bytes : 3'd1;
    next_rx_len = (s_sof ? 16'h0000 : rx_len[rx_p]) + {13'h0000, rx_n};
    next_rx_crc = crc_word(s_sof ? `CRC_INIT : rx_crc[rx_p],
                           mode32 ? s_data : {s_data[7:0], 24'h000000}, rx_n);
    rx_live = s_valid && (s_sof || !rx_drop[rx_p]);  // R3
    rx_over = next_rx_len > max_fs;  // R1
    tx_p = mode32 ? 2'b00 : tx_port;  // R18
    tx_n = mode32 ? tx_bytes : 3'd1;
    next_tx_len = (tx_sof ? 16'h0000 : tx_len[tx_p]) + {13'h0000, tx_n};
    next_tx_crc = crc_word(tx_sof ? `CRC_INIT : tx_crc[tx_p],
                           mode32 ? tx_data : {tx_data[7:0], 24'h000000}, tx_n);
    // inserted crc octets count toward length
    tx_final_len = next_tx_len + (tx_crc_en ? `CRC_BYTES : 16'h0000);  // R1 R16
    tx_any_abort = tx_link_parity_err | tx_queue_start_field_err |
                   tx_buffer_control_descriptor_err;
  end
  // ****************************************************************
  // receive path and counters
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < `CNT_ENTRIES; k = k + 1) begin
        rx_cnt[k] <= 32'h00000000;
      end
      for (k = 0; k < 4; k = k + 1) begin
        rx_len[k] <= 16'h0000;
        rx_crc[k] <= `CRC_INIT;
      end
      rx_drop <= 4'h0;
      rx_ferr <= 4'h0;
      rx_frame_abort <= 1'b0;
      rx_abort_port <= 2'b00;
      rx_port_aborted <= 4'h0;
      stall_cnt <= 16'h0000;
      rx_enable <= 1'b0;
    end else begin
      rx_frame_abort <= 1'b0;
      // throttle framer on processor hold or short-frame slot
      rx_enable <= !rx_hold && (stall_cnt == 16'h0000);  // R19 R17
      if (stall_cnt != 16'h0000) begin
        stall_cnt <= stall_cnt - 16'h0001;
      end
      if (rx_live) begin
        rx_len[rx_p] <= next_rx_len;
        rx_crc[rx_p] <= next_rx_crc;
        rx_cnt[{`LOC_OCTET_BASE, rx_p}] <= rx_cnt[{`LOC_OCTET_BASE, rx_p}] +
                                           {29'h00000000, rx_n};  // R6
        if (s_sof) begin
          // new packet lifts the inhibit and port record
          rx_drop[rx_p] <= 1'b0;  // R3
          rx_port_aborted[rx_p] <= 1'b0;
          rx_ferr[rx_p] <= s_err;
        end else if (s_err) begin
          rx_ferr[rx_p] <= 1'b1;
        end
        if (rx_over) begin
          // oversize: abort, count once, inhibit port
          rx_drop[rx_p] <= 1'b1;  // R2 R3
          rx_port_aborted[rx_p] <= 1'b1;  // R2
          rx_frame_abort <= 1'b1;  // R2
          rx_abort_port <= rx_p;
          rx_cnt[frame_idx(rx_p, `LOC_LONG)] <=
            rx_cnt[frame_idx(rx_p, `LOC_LONG)] + 32'h00000001;  // R5 R20
        end else if (s_eof) begin
          // classify at frame end
          if (rx_ferr[rx_p] || s_err) begin
            rx_cnt[frame_idx(rx_p, `LOC_ERR)] <=
              rx_cnt[frame_idx(rx_p, `LOC_ERR)] + 32'h00000001;  // R9 R20
          end else if (next_rx_crc != `CRC_RESIDUE) begin
            rx_cnt[frame_idx(rx_p, `LOC_BAD_CRC)] <=
              rx_cnt[frame_idx(rx_p, `LOC_BAD_CRC)] + 32'h00000001;  // R7
          end else begin
            rx_cnt[frame_idx(rx_p, `LOC_GOOD)] <=
              rx_cnt[frame_idx(rx_p, `LOC_GOOD)] + 32'h00000001;  // R8
          end
          // short frame still consumes an 18-byte slot
          if (next_rx_len < `MIN_FRAME_BYTES) begin
            stall_cnt <= mode32 ? ((`MIN_FRAME_BYTES - next_rx_len + 16'h0003) >> 2) :
                                  (`MIN_FRAME_BYTES - next_rx_len);  // R17
          end
        end
      end
    end
  end
  // ****************************************************************
  // transmit path, crc insertion and counters
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < `CNT_ENTRIES; j = j + 1) begin
        tx_cnt[j] <= 32'h00000000;
      end
      for (j = 0; j < 4; j = j + 1) begin
        tx_len[j] <= 16'h0000;
        tx_crc[j] <= `CRC_INIT;
      end
      tx_abort <= 1'b0;
      tx_free_return <= 1'b0;
      tx_fcs <= 32'h00000000;
      tx_fcs_valid <= 1'b0;
      tx_fcs_port <= 2'b00;
      abort_ind <= 5'h00;
    end else begin
      tx_abort <= 1'b0;
      tx_free_return <= 1'b0;
      tx_fcs_valid <= 1'b0;
      if (tx_valid) begin
        tx_len[tx_p] <= next_tx_len;
        tx_crc[tx_p] <= next_tx_crc;
        // octets of every frame, errored or not
        tx_cnt[{`LOC_OCTET_BASE, tx_p}] <= tx_cnt[{`LOC_OCTET_BASE, tx_p}] +
          {29'h00000000, tx_n} +
          ((tx_eof && tx_crc_en && !tx_any_abort) ? 32'h00000004 : 32'h00000000);  // R11
        if (tx_any_abort) begin
          // egress abort: count, record cause, hold buffers on bad descriptor
          tx_abort <= 1'b1;  // R12
          tx_cnt[{`LOC_ABORT_BASE, tx_p}] <=
            tx_cnt[{`LOC_ABORT_BASE, tx_p}] + 32'h00000001;  // R12 R20
          abort_ind <= {tx_buffer_control_descriptor_err, tx_queue_start_field_err,
                        tx_link_parity_err, tx_p};  // R13
          tx_free_return <= !tx_buffer_control_descriptor_err;  // R14
        end else if (tx_eof) begin
          tx_free_return <= 1'b1;
          if (tx_crc_en) begin
            // append computed crc; disabled frames go out as is
            tx_fcs <= ~next_tx_crc;  // R16
            tx_fcs_valid <= 1'b1;  // R16
            tx_fcs_port <= tx_p;
          end
          if (tx_underrun && (EARLY_REVISION != 0)) begin
            tx_cnt[frame_idx(tx_p, `LOC_ERR)] <=
              tx_cnt[frame_idx(tx_p, `LOC_ERR)] + 32'h00000001;  // R15 R20
          end else if (tx_final_len > max_fs) begin
            tx_cnt[frame_idx(tx_p, `LOC_LONG)] <=
              tx_cnt[frame_idx(tx_p, `LOC_LONG)] + 32'h00000001;  // R10 R1
          end else if (!tx_crc_en && (next_tx_crc != `CRC_RESIDUE)) begin
            tx_cnt[frame_idx(tx_p, `LOC_BAD_CRC)] <=
              tx_cnt[frame_idx(tx_p, `LOC_BAD_CRC)] + 32'h00000001;  // R10 R7
          end else begin
            tx_cnt[frame_idx(tx_p, `LOC_GOOD)] <=
              tx_cnt[frame_idx(tx_p, `LOC_GOOD)] + 32'h00000001;  // R10 R8
          end
        end
      end
    end
  end
  // ****************************************************************
  // register read decode
  // ****************************************************************
  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if ((araddr & `CNT_WINDOW_MASK) == `OFS_RX_CNT_BASE) begin
      if (araddr[7:2] < 6'd20) begin
        rd_val = rx_cnt[araddr[6:2]];
      end else begin
        rd_err = 1'b1;
      end
    end else if ((araddr & `CNT_WINDOW_MASK) == `OFS_TX_CNT_BASE) begin
      if (araddr[7:2] < 6'd24) begin
        rd_val = tx_cnt[araddr[6:2]];
      end else begin
        rd_err = 1'b1;
      end
    end else begin
      case (araddr)
        `OFS_CTRL: rd_val = {31'h00000000, mode32};
        `OFS_MAX_FS: rd_val = {16'h0000, max_fs};
        `OFS_ABORT_IND: rd_val = {27'h0000000, abort_ind};
        `OFS_STATUS: rd_val = {23'h000000, stall_cnt != 16'h0000, rx_drop, rx_port_aborted};
        default: rd_err = 1'b1;
      endcase
    end
  end
  // ****************************************************************
  // axi4-lite slave handshakes
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      mode32 <= 1'b0;
      max_fs <= `MAX_FS_RESET;
    end else begin
      // address and data taken in either order
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      // both halves held: commit and answer
      if (aw_full && w_full && !bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        case (wr_addr)
          `OFS_CTRL: begin
            // mode change mid-frame corrupts lengths; set while idle
            if (wr_strb[0]) begin
              mode32 <= wr_data[`CTRL_MODE32_BIT];  // R18
            end
          end
          `OFS_MAX_FS: begin
            if (wr_strb[0]) begin
              max_fs[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
              max_fs[15:8] <= wr_data[15:8];
            end
          end
          `OFS_ABORT_IND, `OFS_STATUS: bresp <= `RESP_OKAY;
          default: begin
            if (((wr_addr & `CNT_WINDOW_MASK) != `OFS_RX_CNT_BASE) &&
                ((wr_addr & `CNT_WINDOW_MASK) != `OFS_TX_CNT_BASE)) begin
              bresp <= `RESP_DECERR;
            end
          end
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // read answered one cycle after address taken
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_err ? `RESP_DECERR : `RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // sonet_packet_mac_stats

// ==== src/pos_mac_stats_regs.vh ====
`ifndef POS_MAC_STATS_REGS_VH
`define POS_MAC_STATS_REGS_VH
// ****************************************************************
// register byte offsets on the axi4-lite bus
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_MAX_FS 12'h004
`define OFS_ABORT_IND 12'h008
`define OFS_STATUS 12'h00C
`define OFS_RX_CNT_BASE 12'h100
`define OFS_TX_CNT_BASE 12'h200
`define CNT_WINDOW_MASK 12'hF00
// ****************************************************************
// fields and reset values
// ****************************************************************
`define CTRL_MODE32_BIT 0
`define MAX_FS_RESET 16'h0600
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
// ****************************************************************
// counter ram locations
// ****************************************************************
`define CNT_ENTRIES 24
`define LOC_LONG 2'h0
`define LOC_BAD_CRC 2'h1
`define LOC_GOOD 2'h2
`define LOC_ERR 2'h3
`define LOC_OCTET_BASE 3'h4
`define LOC_ABORT_BASE 3'h5
// ****************************************************************
// frame timing and crc
// ****************************************************************
`define MIN_FRAME_BYTES 16'h0012
`define CRC_BYTES 16'h0004
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY_REV 32'hEDB88320
`define CRC_RESIDUE 32'hDEBB20E3
`endif

// ==== testbench/sonet_packet_mac_stats_assertions.sv ====
`timescale 1ns/1ps
// ****************************************************************
// port-level checker
// ****************************************************************
module sonet_packet_mac_stats_assertions (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // register bus
  input logic awvalid, awready, wvalid, wready, bvalid, bready,
  input logic [1:0] bresp,
  input logic arvalid, arready, rvalid, rready,
  input logic [31:0] rdata,
  // receive side
  input logic rx_hold, rx_enable, rx_frame_abort,
  input logic [1:0] rx_abort_port,
  input logic [3:0] rx_port_aborted,
  // transmit side
  input logic tx_valid, tx_eof, tx_crc_en,
  input logic [1:0] tx_port,
  input logic tx_link_parity_err, tx_queue_start_field_err, tx_buffer_control_descriptor_err,
  input logic tx_abort, tx_free_return, tx_fcs_valid,
  input logic [1:0] tx_fcs_port
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // any of the three egress faults on a beat
  wire tx_fault = tx_link_parity_err | tx_queue_start_field_err | tx_buffer_control_descriptor_err;
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed before taken");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed before taken");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  abort_mark_a: assert property (rx_frame_abort |=> rx_port_aborted[rx_abort_port])
    else $error("aborted port not marked");
  hold_stops_a: assert property (rx_hold |=> !rx_enable)
    else $error("receive enabled while held");
  tx_abort_a: assert property (tx_valid && tx_fault |=> tx_abort)
    else $error("egress fault did not abort");
  keep_buffers_a: assert property (tx_valid && tx_buffer_control_descriptor_err
    |=> !tx_free_return)
    else $error("buffers freed after descriptor fault");
  crc_insert_a: assert property (tx_valid && tx_eof && tx_crc_en && !tx_fault
    |=> tx_fcs_valid && tx_fcs_port == $past(tx_port))
    else $error("crc not produced for frame end");
endmodule // sonet_packet_mac_stats_assertions

// ==== testbench/framer_model.sv ====
`timescale 1ns/1ps
`include "pos_mac_stats_regs.vh"
// ****************************************************************
// receive-side framer model
// ****************************************************************
module framer_model (
  // clock and flow control
  input wire aclk,
  input wire rx_enable,
  // receive pins
  output logic rx_valid, rx_sof, rx_eof, rx_err,
  output logic [1:0] rx_port,
  output logic [2:0] rx_bytes,
  output logic [31:0] rx_data
);
  logic [7:0] b [0:63]; // frame bytes incl fcs
  initial begin
    {rx_valid, rx_sof, rx_eof, rx_err, rx_port, rx_bytes, rx_data} = '0;
  end
  // reflected crc-32, one byte
  function automatic [31:0] crc8(input [31:0] c, input [7:0] d);
    c = c ^ {24'h000000, d};
    repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY_REV : c >> 1;
    return c;
  endfunction
  // one frame: payload then fcs, bad flips one fcs bit, er raises error at end
  task automatic send(input [1:0] p, input int n, input bit bad, input bit er, input bit w);
    logic [31:0] c;
    int i;
    int s;
    c = `CRC_INIT;
    s = w ? 4 : 1;
    for (i = 0; i < n - 4; i++) begin
      b[i] = i[7:0] + {2'h0, p, 4'h0};
      c = crc8(c, b[i]);
    end
    c = ~c ^ {31'h00000000, bad};
    for (i = 0; i < 4; i++) b[n - 4 + i] = c[8 * i +: 8];
    for (i = 0; i < n; i += s) begin
      @(posedge aclk);
      while (!rx_enable) @(posedge aclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i + s >= n);
      rx_err <= er && (i + s >= n);
      rx_port <= p;
      rx_bytes <= w ? 3'h4 : 3'h1;
      rx_data <= w ? {b[i], b[i + 1], b[i + 2], b[i + 3]} : {24'h000000, b[i]};
    end
    // released: data shows the inverse, not the last value
    @(posedge aclk);
    {rx_valid, rx_sof, rx_eof, rx_err} <= 4'h0;
    rx_data <= ~rx_data;
  endtask
endmodule // framer_model

// ==== testbench/sonet_packet_mac_stats_test.sv ====
`timescale 1ns/1ps
// ****************************************************************
// top-level bench
// ****************************************************************
module sonet_packet_mac_stats_test;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, tx_data, tx_fcs;
  logic [3:0] wstrb, rx_port_aborted;
  logic [1:0] bresp, rresp, rx_port, rx_abort_port, tx_port, tx_fcs_port;
  logic rx_valid, rx_sof, rx_eof, rx_err, rx_enable, rx_hold, rx_frame_abort;
  logic [2:0] rx_bytes, tx_bytes;
  logic [31:0] rx_data;
  logic tx_valid, tx_sof, tx_eof, tx_crc_en, tx_underrun, tx_abort, tx_free_return, tx_fcs_valid;
  logic tx_link_parity_err, tx_queue_start_field_err, tx_buffer_control_descriptor_err;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  sonet_packet_mac_stats u_dut (.*);
  framer_model u_fr (.aclk(aclk), .rx_enable(rx_enable), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_err(rx_err), .rx_port(rx_port), .rx_bytes(rx_bytes), .rx_data(rx_data));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic axi_wr(input [11:0] a, input [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input [11:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input [11:0] a, input [31:0] e);
    axi_rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // one egress frame, fault kind e on its last beat
  task automatic tx_frame(input [1:0] p, input int n, input bit ce, input int e);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      {tx_valid, tx_sof, tx_eof, tx_port, tx_crc_en} <= {1'b1, i == 0, i == n - 1, p, ce};
      tx_data <= {24'h000000, i[7:0]};
      tx_link_parity_err <= (e == 1 && i == n - 1);
      tx_queue_start_field_err <= (e == 2 && i == n - 1);
      tx_buffer_control_descriptor_err <= (e == 3 && i == n - 1);
    end
    @(posedge aclk);
    {tx_valid, tx_sof, tx_eof, tx_link_parity_err} <= 4'h0;
    {tx_queue_start_field_err, tx_buffer_control_descriptor_err} <= 2'h0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d comparisons", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    {rx_hold, tx_valid, tx_sof, tx_eof, tx_port, tx_data, tx_crc_en, tx_underrun} = '0;
    {tx_link_parity_err, tx_queue_start_field_err, tx_buffer_control_descriptor_err} = '0;
    wstrb = 4'hF;
    tx_bytes = 3'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(12'h004, 32'h00000600);
    rd_chk(12'h000, 32'h00000000);
    axi_rd(12'h010);
    chk("unmapped read resp", 32'h00000003, {30'h0, r});
    axi_wr(12'h010, 32'h00000001);
    chk("unmapped write resp", 32'h00000003, {30'h0, r});
    axi_wr(12'h004, 32'h00000020);
    rd_chk(12'h004, 32'h00000020);
    // receive: good, held then bad crc, framer error
    u_fr.send(2'h0, 20, 1'b0, 1'b0, 1'b0);
    @(posedge aclk) rx_hold <= 1'b1;
    repeat (5) @(posedge aclk);
    rx_hold <= 1'b0;
    u_fr.send(2'h1, 20, 1'b1, 1'b0, 1'b0);
    u_fr.send(2'h2, 20, 1'b0, 1'b1, 1'b0);
    // oversize then exact-limit frame on the same port
    u_fr.send(2'h3, 40, 1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge aclk);
    chk("port aborted", 32'h00000008, {28'h0, rx_port_aborted});
    u_fr.send(2'h3, 32, 1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge aclk);
    chk("port abort cleared", 32'h00000000, {28'h0, rx_port_aborted});
    u_fr.send(2'h0, 8, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    chk("short slot", 32'h00000000, {31'h0, rx_enable});
    axi_wr(12'h000, 32'h00000001);
    rd_chk(12'h000, 32'h00000001);
    u_fr.send(2'h0, 20, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge aclk);
    rd_chk(12'h108, 32'h00000003);
    rd_chk(12'h140, 32'h00000030);
    rd_chk(12'h114, 32'h00000001);
    rd_chk(12'h144, 32'h00000014);
    rd_chk(12'h12C, 32'h00000001);
    rd_chk(12'h130, 32'h00000001);
    rd_chk(12'h138, 32'h00000001);
    axi_wr(12'h000, 32'h00000000);
    tx_underrun <= 1'b1;
    // transmit: inserted crc, own bad crc, oversize with inserted crc
    tx_frame(2'h1, 14, 1'b1, 0);
    d = 32'hFFFFFFFF;
    for (int i = 0; i < 112; i++) begin
      d = (d >> 1) ^ ((d[0] ^ i[3 + i % 8]) ? 32'hEDB88320 : 32'h00000000);
    end
    chk("tx fcs", ~d, tx_fcs);
    tx_frame(2'h0, 20, 1'b0, 0);
    tx_frame(2'h3, 30, 1'b1, 0);
    rd_chk(12'h218, 32'h00000001);
    rd_chk(12'h244, 32'h00000012);
    rd_chk(12'h204, 32'h00000001);
    rd_chk(12'h230, 32'h00000001);
    rd_chk(12'h20C, 32'h00000000);
    // each egress fault kind on its own port
    for (int k = 1; k < 4; k++) begin
      tx_frame(k[1:0] == 2'h1 ? 2'h0 : k[1:0], 4, 1'b1, k);
      rd_chk(12'h250 + 12'h004 * (k == 1 ? 0 : k), 32'h00000001);
      rd_chk(12'h008, (32'h1 << (k + 1)) | (k == 1 ? 0 : k));
    end
    summarize;
  end
endmodule // sonet_packet_mac_stats_test
bind sonet_packet_mac_stats sonet_packet_mac_stats_assertions u_chk (.aclk(aclk),
  .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rx_hold(rx_hold), .rx_enable(rx_enable),
  .rx_frame_abort(rx_frame_abort), .rx_abort_port(rx_abort_port),
  .rx_port_aborted(rx_port_aborted), .tx_valid(tx_valid), .tx_eof(tx_eof),
  .tx_crc_en(tx_crc_en), .tx_port(tx_port), .tx_link_parity_err(tx_link_parity_err),
  .tx_queue_start_field_err(tx_queue_start_field_err), .tx_abort(tx_abort),
  .tx_buffer_control_descriptor_err(tx_buffer_control_descriptor_err),
  .tx_free_return(tx_free_return), .tx_fcs_valid(tx_fcs_valid), .tx_fcs_port(tx_fcs_port));
